// ===== rtl/misc_irq_clock_control.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
// Behaviour
// - Port B field bits 7:6: fall+low, rise, fall, both edges.
// - Group B invert flips port B low group; both-edges unchanged.
// - Field bits 4:3 set port A low and port F low groups alike.
// - Group A invert flips port A group only, port F unaffected.
// - Sensitivity fields accept writes only at interrupt mask level 3.
// - Clock-out enable drives oscillator/2 on port F bit 0 pin.
// - Oscillator-half output suspended during active-halt.
// - Slow divider: 00 /4, 10 /8, 01 /16, 11 /32.
// - Slow mode clear gives oscillator/2, set uses divider field.
// - Beep on port F bit 1: off, ~2 kHz, ~1 kHz, ~500 Hz, 50% duty.
// - Beep keeps running during active-halt.
// - Top irq edge: 0 falling, 1 rising; writable only when disabled.
// - Top irq enable gates dedicated pin interrupt requests.
// - Slave-select from pin, or from internal bit when source bit set.
// - Both registers read/write, reset to zero.
module misc_irq_clock_control (
	input wire logic mclk_in, // System clock, stands for oscillator
	input wire logic rst_b_in, // Async reset, active low
	input wire logic [7:0] addr_in, // Register byte address
	input wire logic [7:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	output logic [7:0] rdata_out, // Read data, cycle after strobe
	input wire logic irq_mask_level_high_in, // CPU mask bit 1
	input wire logic irq_mask_level_low_in, // CPU mask bit 0
	input wire logic active_halt_in, // Active-halt power mode
	input wire logic ext_irq_porta_low_in, // Port A group pin level
	input wire logic ext_irq_portf_low_in, // Port F group pin level
	input wire logic ext_irq_portb_low_in, // Port B low group pin level
	input wire logic ext_irq_portb_high_in, // Port B high group pin level
	input wire logic top_level_interrupt_in, // Dedicated top irq pin
	input wire logic slave_select_pin_in, // External slave-select pin
	output logic [3:0] ext_irq_req_out, // Group requests: A, F, B low, B high
	output logic top_irq_req_out, // Top-level interrupt request pulse
	output logic port_f_bit_zero_pin_out, // Clock-out level
	output logic port_f_bit_zero_alt_out, // Clock-out owns the pin
	output logic port_f_bit_one_pin_out, // Beep level
	output logic port_f_bit_one_alt_out, // Beep owns the pin
	output logic cpu_clk_en_out, // CPU clock enable pulse
	output logic [2:0] cpu_div_log_out, // log2 of CPU divide ratio
	output logic slave_select_out, // Slave-select to serial peripheral
	output logic port_c_bit_seven_free_out // Pin free for I/O
);
	// Reset release
	logic [1:0] rst_sync_r;
	logic rst_b;
	// Register file and read port
	logic [7:0] ctl1_r;
	logic [7:0] ctl1_nxt;
	logic [7:0] ctl2_r;
	logic [7:0] ctl2_nxt;
	logic [7:0] rdata_nxt;
	// Pin synchronisers and edge history
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	logic [4:0] pin_d_r;
	logic [4:0] pin_s1_nxt;
	logic [3:0] ext_req_nxt;
	logic top_req_nxt;
	// Clock-out
	logic half_r;
	logic half_nxt;
	logic clk_out_nxt;
	// CPU divider
	logic [4:0] cpu_cnt_r;
	logic [4:0] cpu_cnt_nxt;
	logic [2:0] div_log_nxt;
	logic cpu_en_nxt;
	// Beep tone
	logic [14:0] beep_cnt_r;
	logic [14:0] beep_cnt_nxt;
	logic [14:0] beep_half;
	logic beep_r;
	logic beep_nxt;
	// Slave-select
	logic ss_nxt;
	logic free_nxt;
	// Bus decode
	logic level3;
	logic sel1;
	logic sel2;

	// Reset release through two flops
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_r[1];

	assign level3 = {irq_mask_level_high_in, irq_mask_level_low_in} == misc_ctrl_pkg::IRQ_MASK_LEVEL_3;
	assign sel1 = addr_in == misc_ctrl_pkg::ADDR_MISC_CONTROL_ONE;
	assign sel2 = addr_in == misc_ctrl_pkg::ADDR_MISC_CONTROL_TWO;

	// Register writes with guarded fields
	always_comb begin
		ctl1_nxt = ctl1_r;
		ctl2_nxt = ctl2_r;
		if (wr_in && sel1) begin
			ctl1_nxt[misc_ctrl_pkg::CLOCK_OUT_EN_BIT] = wdata_in[misc_ctrl_pkg::CLOCK_OUT_EN_BIT];
			ctl1_nxt[misc_ctrl_pkg::SLOW_DIV_HI:0] = wdata_in[misc_ctrl_pkg::SLOW_DIV_HI:0];
			if (level3) begin
				ctl1_nxt[misc_ctrl_pkg::PORTB_SENSE_HI:misc_ctrl_pkg::PORTB_SENSE_LO] =
					wdata_in[misc_ctrl_pkg::PORTB_SENSE_HI:misc_ctrl_pkg::PORTB_SENSE_LO];
				ctl1_nxt[misc_ctrl_pkg::PORTA_F_SENSE_HI:misc_ctrl_pkg::PORTA_F_SENSE_LO] =
					wdata_in[misc_ctrl_pkg::PORTA_F_SENSE_HI:misc_ctrl_pkg::PORTA_F_SENSE_LO];
			end
		end else if (wr_in && sel2) begin
			ctl2_nxt = wdata_in;
			// Edge select frozen while enabled, judged on the old enable
			if (ctl2_r[misc_ctrl_pkg::TOP_EN_BIT]) begin
				ctl2_nxt[misc_ctrl_pkg::TOP_EDGE_BIT] = ctl2_r[misc_ctrl_pkg::TOP_EDGE_BIT];
			end
		end
	end

	// Read mux, unmapped reads zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_in && sel1) begin
			rdata_nxt = ctl1_r;
		end else if (rd_in && sel2) begin
			rdata_nxt = ctl2_r;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			ctl1_r <= misc_ctrl_pkg::RESET_VALUE;
			ctl2_r <= misc_ctrl_pkg::RESET_VALUE;
			rdata_out <= 8'h00;
		end else begin
			ctl1_r <= ctl1_nxt;
			ctl2_r <= ctl2_nxt;
			rdata_out <= rdata_nxt;
		end
	end

	// Sensitivity decode: level request or edge pulse
	function automatic logic sense_hit(input logic [1:0] mode, input logic inv,
			input logic now, input logic prev);
		logic rise;
		logic fall;
		logic act;
		rise = now & ~prev;
		fall = ~now & prev;
		act = inv ? now : ~now;
		case (mode)
			misc_ctrl_pkg::SENSE_FALL_LOW: sense_hit = inv ? (rise | act) : (fall | act);
			misc_ctrl_pkg::SENSE_RISE: sense_hit = inv ? fall : rise;
			misc_ctrl_pkg::SENSE_FALL: sense_hit = inv ? rise : fall;
			default: sense_hit = rise | fall;
		endcase
	endfunction

	// Pin sync and event detection
	always_comb begin
		pin_s1_nxt = {top_level_interrupt_in, ext_irq_portb_high_in, ext_irq_portb_low_in,
			ext_irq_portf_low_in, ext_irq_porta_low_in};
		ext_req_nxt[0] = sense_hit(ctl1_r[misc_ctrl_pkg::PORTA_F_SENSE_HI:misc_ctrl_pkg::PORTA_F_SENSE_LO],
			ctl2_r[misc_ctrl_pkg::GROUP_A_INV_BIT], pin_s2_r[0], pin_d_r[0]);
		ext_req_nxt[1] = sense_hit(ctl1_r[misc_ctrl_pkg::PORTA_F_SENSE_HI:misc_ctrl_pkg::PORTA_F_SENSE_LO],
			1'b0, pin_s2_r[1], pin_d_r[1]);
		ext_req_nxt[2] = sense_hit(ctl1_r[misc_ctrl_pkg::PORTB_SENSE_HI:misc_ctrl_pkg::PORTB_SENSE_LO],
			ctl2_r[misc_ctrl_pkg::GROUP_B_INV_BIT], pin_s2_r[2], pin_d_r[2]);
		ext_req_nxt[3] = sense_hit(ctl1_r[misc_ctrl_pkg::PORTB_SENSE_HI:misc_ctrl_pkg::PORTB_SENSE_LO],
			1'b0, pin_s2_r[3], pin_d_r[3]);
		// Edge chosen by edge bit, gated by enable
		top_req_nxt = ctl2_r[misc_ctrl_pkg::TOP_EN_BIT] &&
			(ctl2_r[misc_ctrl_pkg::TOP_EDGE_BIT] ? (pin_s2_r[4] & ~pin_d_r[4])
			: (~pin_s2_r[4] & pin_d_r[4]));
	end

	always_ff @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_r <= 5'h1f;
			pin_s2_r <= 5'h1f;
			pin_d_r <= 5'h1f;
			ext_irq_req_out <= 4'h0;
			top_irq_req_out <= 1'b0;
		end else begin
			pin_s1_r <= pin_s1_nxt;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
			ext_irq_req_out <= ext_req_nxt;
			top_irq_req_out <= top_req_nxt;
		end
	end

	// Clock-out: the half-rate flop runs always, only the pin is gated
	always_comb begin
		half_nxt = ~half_r;
		// Gated ahead of the pin flop so halt silences it within a cycle
		clk_out_nxt = ctl1_r[misc_ctrl_pkg::CLOCK_OUT_EN_BIT] && !active_halt_in && half_r;
	end

	always_ff @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			half_r <= 1'b0;
			port_f_bit_zero_pin_out <= 1'b0;
			port_f_bit_zero_alt_out <= 1'b0;
		end else begin
			half_r <= half_nxt;
			port_f_bit_zero_pin_out <= clk_out_nxt;
			port_f_bit_zero_alt_out <= ctl1_r[misc_ctrl_pkg::CLOCK_OUT_EN_BIT];
		end
	end

	// CPU divider: an enable pulse, not a gated clock, to keep one domain
	always_comb begin
		if (!ctl1_r[misc_ctrl_pkg::SLOW_MODE_BIT]) begin
			div_log_nxt = misc_ctrl_pkg::CPU_DIV_LOG_NORMAL;
		end else begin
			case (ctl1_r[misc_ctrl_pkg::SLOW_DIV_HI:misc_ctrl_pkg::SLOW_DIV_LO])
				2'h0: div_log_nxt = misc_ctrl_pkg::CPU_DIV_LOG_4;
				2'h2: div_log_nxt = misc_ctrl_pkg::CPU_DIV_LOG_8;
				2'h1: div_log_nxt = misc_ctrl_pkg::CPU_DIV_LOG_16;
				default: div_log_nxt = misc_ctrl_pkg::CPU_DIV_LOG_32;
			endcase
		end
		// One enable pulse per divided period
		cpu_cnt_nxt = cpu_cnt_r + 5'h01;
		cpu_en_nxt = 1'b0;
		// Compare with >= so a shorter ratio never strands the counter
		if (cpu_cnt_r >= 5'((1 << div_log_nxt) - 1)) begin
			cpu_cnt_nxt = 5'h00;
			cpu_en_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			cpu_cnt_r <= 5'h00;
			cpu_clk_en_out <= 1'b0;
			cpu_div_log_out <= misc_ctrl_pkg::CPU_DIV_LOG_NORMAL;
		end else begin
			cpu_cnt_r <= cpu_cnt_nxt;
			cpu_clk_en_out <= cpu_en_nxt;
			cpu_div_log_out <= div_log_nxt;
		end
	end

	// Beep tone: half period counter toggling a square wave
	always_comb begin
		case (ctl2_r[misc_ctrl_pkg::BEEP_HI:misc_ctrl_pkg::BEEP_LO])
			misc_ctrl_pkg::BEEP_2K: beep_half = misc_ctrl_pkg::BEEP_HALF_2K;
			misc_ctrl_pkg::BEEP_1K: beep_half = misc_ctrl_pkg::BEEP_HALF_1K;
			default: beep_half = misc_ctrl_pkg::BEEP_HALF_500;
		endcase
		// Active-halt deliberately not gating the beep
		beep_cnt_nxt = beep_cnt_r + 15'h0001;
		beep_nxt = beep_r;
		if (ctl2_r[misc_ctrl_pkg::BEEP_HI:misc_ctrl_pkg::BEEP_LO] == misc_ctrl_pkg::BEEP_OFF) begin
			beep_cnt_nxt = 15'h0000;
			beep_nxt = 1'b0;
		end else if (beep_cnt_r >= beep_half - 15'h0001) begin
			// A code change to a half the count has already passed ends the current half at once
			beep_cnt_nxt = 15'h0000;
			beep_nxt = ~beep_r;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			beep_cnt_r <= 15'h0000;
			beep_r <= 1'b0;
			port_f_bit_one_pin_out <= 1'b0;
			port_f_bit_one_alt_out <= 1'b0;
		end else begin
			beep_cnt_r <= beep_cnt_nxt;
			beep_r <= beep_nxt;
			// Pin copies the next level so it lines up with beep_r
			port_f_bit_one_pin_out <= beep_nxt;
			port_f_bit_one_alt_out <= ctl2_r[misc_ctrl_pkg::BEEP_HI:misc_ctrl_pkg::BEEP_LO]
				!= misc_ctrl_pkg::BEEP_OFF;
		end
	end

	// Slave-select source; the pin is used raw, the peripheral syncs it
	always_comb begin
		ss_nxt = ctl2_r[misc_ctrl_pkg::SS_SOURCE_BIT] ? ctl2_r[misc_ctrl_pkg::SS_VALUE_BIT]
			: slave_select_pin_in;
		free_nxt = ctl2_r[misc_ctrl_pkg::SS_SOURCE_BIT];
	end

	// Deselected after reset, so the peripheral stays idle
	always_ff @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			slave_select_out <= 1'b1;
			port_c_bit_seven_free_out <= 1'b0;
		end else begin
			slave_select_out <= ss_nxt;
			port_c_bit_seven_free_out <= free_nxt;
		end
	end
endmodule

// ===== rtl/misc_ctrl_pkg.sv
package misc_ctrl_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_MISC_CONTROL_ONE = 8'h20;
	localparam logic [7:0] ADDR_MISC_CONTROL_TWO = 8'h40;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Field positions, control one
	localparam int PORTB_SENSE_HI = 7;
	localparam int PORTB_SENSE_LO = 6;
	localparam int CLOCK_OUT_EN_BIT = 5;
	localparam int PORTA_F_SENSE_HI = 4;
	localparam int PORTA_F_SENSE_LO = 3;
	localparam int SLOW_DIV_HI = 2;
	localparam int SLOW_DIV_LO = 1;
	localparam int SLOW_MODE_BIT = 0;
	// Field positions, control two
	localparam int GROUP_A_INV_BIT = 7;
	localparam int GROUP_B_INV_BIT = 6;
	localparam int BEEP_HI = 5;
	localparam int BEEP_LO = 4;
	localparam int TOP_EDGE_BIT = 3;
	localparam int TOP_EN_BIT = 2;
	localparam int SS_SOURCE_BIT = 1;
	localparam int SS_VALUE_BIT = 0;
	// Sensitivity encodings
	localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] SENSE_RISE = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;
	// Slow divider codes (log2 of divide ratio)
	localparam logic [2:0] CPU_DIV_LOG_NORMAL = 3'h1;
	localparam logic [2:0] CPU_DIV_LOG_4 = 3'h2;
	localparam logic [2:0] CPU_DIV_LOG_8 = 3'h3;
	localparam logic [2:0] CPU_DIV_LOG_16 = 3'h4;
	localparam logic [2:0] CPU_DIV_LOG_32 = 3'h5;
	// Beep half periods in oscillator cycles (16 MHz: 2 kHz, 1 kHz, 500 Hz)
	localparam logic [14:0] BEEP_HALF_2K = 15'h0fa0;
	localparam logic [14:0] BEEP_HALF_1K = 15'h1f40;
	localparam logic [14:0] BEEP_HALF_500 = 15'h3e80;
	localparam logic [1:0] BEEP_OFF = 2'h0;
	localparam logic [1:0] BEEP_2K = 2'h1;
	localparam logic [1:0] BEEP_1K = 2'h2;
	localparam logic [1:0] IRQ_MASK_LEVEL_3 = 2'h3;
endpackage

// ===== verif/misc_ctrl_chk_sva.sv
`timescale 1ns/100ps
// Watches register port, clock-out, divider and top request outputs
module misc_ctrl_chk (
	input wire logic mclk_in, // Clock
	input wire logic rst_b_in, // Reset, active low
	input wire logic [7:0] addr_in, // Address
	input wire logic [7:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	input wire logic [7:0] rdata_out, // Read data
	input wire logic active_halt_in, // Active-halt mode
	input wire logic port_f_bit_zero_pin_out, // Clock-out level
	input wire logic port_f_bit_zero_alt_out, // Clock-out owns pin
	input wire logic cpu_clk_en_out, // CPU clock enable
	input wire logic top_irq_req_out // Top request
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// Write then read of one register, no gap
	sequence wr_rd(logic [7:0] a);
		wr_in && addr_in == a ##1 rd_in && addr_in == a;
	endsequence
	// Clock-out owned two cycles, awake three: the pin flop lags halt by one
	sequence co_live;
		!active_halt_in ##1 port_f_bit_zero_alt_out && !active_halt_in
			##1 port_f_bit_zero_alt_out && !active_halt_in;
	endsequence
	unmap_rd_a: assert property (
		rd_in && addr_in != 8'h20 && addr_in != 8'h40 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data outside its cycle");
	one_back_a: assert property (wr_rd(8'h20) |=>
		(rdata_out & 8'h27) == ($past(wdata_in, 2) & 8'h27)) else $error("control one lost");
	two_back_a: assert property (wr_rd(8'h40) |=>
		(rdata_out & 8'hf7) == ($past(wdata_in, 2) & 8'hf7)) else $error("control two lost");
	clk_toggle_a: assert property (co_live |-> $changed(port_f_bit_zero_pin_out))
		else $error("clock-out not toggling");
	halt_still_a: assert property (active_halt_in |=> !port_f_bit_zero_pin_out)
		else $error("clock-out alive in halt");
	cpu_gap_a: assert property (cpu_clk_en_out |=> !cpu_clk_en_out)
		else $error("cpu enable faster than half");
	top_pulse_a: assert property (top_irq_req_out |=> !top_irq_req_out)
		else $error("top request longer than a pulse");
endmodule

// ===== verif/pin_world.sv
`timescale 1ns/100ps
// Pins beside the block, idle high like pulled-up inputs
module pin_world (
	input wire logic mclk_in, // Clock
	input wire logic [5:0] want_in, // Levels asked by the bench
	output logic [5:0] pins_out // A, F, B low, B high, top, slave select
);
	// Pins move only just after an edge, never mid-cycle
	initial pins_out = 6'h3f;
	always @(posedge mclk_in) begin
		pins_out <= want_in;
	end
endmodule

// ===== verif/misc_irq_clock_control_tb_top.sv
`timescale 1ns/100ps
module misc_irq_clock_control_tb_top;
	logic mclk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic lv_hi = 1'b1, lv_lo = 1'b1, halt = 1'b0, top_req, f0, f0_alt, f1, f1_alt, cpu_en, ss, free;
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
	logic [5:0] want = 6'h3f, pins;
	logic [3:0] req, seen;
	logic [2:0] div_log;
	logic [15:0] n_en, n_f0, n_top, n;
	int err_total = 0, checks_done = 0;
	pin_world world (.mclk_in, .want_in(want), .pins_out(pins));
	misc_irq_clock_control dut (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .irq_mask_level_high_in(lv_hi), .irq_mask_level_low_in(lv_lo),
		.active_halt_in(halt), .ext_irq_porta_low_in(pins[0]), .ext_irq_portf_low_in(pins[1]),
		.ext_irq_portb_low_in(pins[2]), .ext_irq_portb_high_in(pins[3]),
		.top_level_interrupt_in(pins[4]), .slave_select_pin_in(pins[5]), .ext_irq_req_out(req),
		.top_irq_req_out(top_req), .port_f_bit_zero_pin_out(f0), .port_f_bit_zero_alt_out(f0_alt),
		.port_f_bit_one_pin_out(f1), .port_f_bit_one_alt_out(f1_alt), .cpu_clk_en_out(cpu_en),
		.cpu_div_log_out(div_log), .slave_select_out(ss), .port_c_bit_seven_free_out(free));
	// 200 MHz clock
	always #2.5 mclk_in = ~mclk_in;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(negedge mclk_in);
		chk({8'h00, rdata_out}, {8'h00, e});
	endtask
	// Sample outputs mid-cycle, away from edge races
	task automatic watch(input int k);
		seen = 4'h0;
		n_en = 16'h0;
		n_f0 = 16'h0;
		n_top = 16'h0;
		repeat (k) begin
			@(negedge mclk_in);
			seen |= req;
			n_en += {15'h0, cpu_en};
			n_f0 += {15'h0, f0};
			n_top += {15'h0, top_req};
		end
	endtask
	// One half period is measured after waiting out the first edge, which may come late
	task automatic beep(input logic [1:0] c, input logic [15:0] half);
		logic p;
		wr(8'h40, {2'h0, c, 4'h0});
		repeat (2) begin
			p = f1;
			for (n = 16'h0; n < 16'h9c40 && f1 === p; n++) @(negedge mclk_in);
		end
		chk(n, half);
		chk({15'h0, f1_alt}, 16'h1);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Hang guard, well past the expected run
	initial begin
		#750000;
		err_total++;
		conclude;
	end
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rd(8'h20, 8'h00);
		rd(8'h40, 8'h00);
		rd(8'h33, 8'h00);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'hff);
		@(posedge mclk_in) lv_lo <= 1'b0;
		wr(8'h20, 8'h00);
		rd(8'h20, 8'hd8);
		@(posedge mclk_in) lv_lo <= 1'b1;
		wr(8'h20, 8'h00);
		@(posedge mclk_in) want <= 6'h30;
		watch(12);
		chk({12'h0, req}, 16'hf);
		@(posedge mclk_in) want <= 6'h3f;
		wr(8'h20, 8'h48);
		wr(8'h40, 8'hc0);
		watch(8);
		@(posedge mclk_in) want <= 6'h30;
		watch(10);
		chk({12'h0, seen}, 16'h5);
		chk({12'h0, req}, 16'h0);
		@(posedge mclk_in) want <= 6'h3f;
		watch(10);
		chk({12'h0, seen}, 16'ha);
		wr(8'h40, 8'h08);
		wr(8'h40, 8'h0c);
		wr(8'h40, 8'h04);
		rd(8'h40, 8'h0c);
		@(posedge mclk_in) want <= 6'h2f;
		watch(10);
		chk(n_top, 16'h0);
		@(posedge mclk_in) want <= 6'h3f;
		watch(10);
		chk(n_top, 16'h1);
		wr(8'h40, 8'h08);
		@(posedge mclk_in) want <= 6'h2f;
		watch(10);
		@(posedge mclk_in) want <= 6'h3f;
		watch(10);
		chk(n_top, 16'h0);
		wr(8'h40, 8'h02);
		watch(6);
		chk({14'h0, free, ss}, 16'h2);
		wr(8'h40, 8'h03);
		watch(6);
		chk({14'h0, free, ss}, 16'h3);
		wr(8'h40, 8'h00);
		@(posedge mclk_in) want <= 6'h1f;
		watch(8);
		chk({14'h0, free, ss}, 16'h0);
		// Write then read with no idle cycle between the strobes
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk_in);
			addr_in <= (k == 0) ? 8'h20 : 8'h40;
			wdata_in <= 8'h27;
			wr_in <= 1'b1;
			@(posedge mclk_in);
			wr_in <= 1'b0;
			rd_in <= 1'b1;
			@(posedge mclk_in);
			rd_in <= 1'b0;
			@(negedge mclk_in);
			chk({8'h00, rdata_out}, 16'h0027);
		end
		// Normal mode, then the four slow codes in order /4, /8, /16, /32
		for (int i = 0; i < 5; i++) begin
			logic [1:0] j;
			j = 2'(i - 1);
			wr(8'h20, (i == 0) ? 8'h20 : {5'h04, j[0], j[1], 1'b1});
			watch(40);
			watch(64);
			chk(n_en, 16'h0040 >> (i + 1));
			chk({13'h0, div_log}, 16'(i + 1));
			chk(n_f0 + {15'h0, f0_alt}, 16'h21);
		end
		@(posedge mclk_in) halt <= 1'b1;
		watch(4);
		watch(64);
		chk(n_f0, 16'h0);
		beep(2'h1, 16'h0fa0);
		beep(2'h2, 16'h1f40);
		beep(2'h3, 16'h3e80);
		wr(8'h40, 8'h00);
		watch(4);
		chk({15'h0, f1_alt}, 16'h0);
		conclude;
	end
endmodule
bind misc_irq_clock_control misc_ctrl_chk chk_i (.mclk_in, .rst_b_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .active_halt_in, .port_f_bit_zero_pin_out,
	.port_f_bit_zero_alt_out, .cpu_clk_en_out, .top_irq_req_out);
